// ==== i2c_to_spi_message_bridge.v ====
`include "bridge_consts.vh"
module i2c_to_spi_message_bridge #(
	parameter [3:0]    ADDR_HIGH       = `ADDR_HIGH_DEF,
	parameter          EXT_CLK_VARIANT = 0,
	parameter          PW              = 8,
	parameter [PW-1:0] DEPTH           = `BUF_DEPTH
) (
	input  wire       ref_clk,
	input  wire       rst_b,
	input  wire       scl,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	input  wire       miso,
	output wire       mosi,
	output wire       serial_shift_clock,
	output wire       slave_select_0_n,
	output wire       slave_select_1_n,
	output wire       slave_select_2_n,
	output wire       slave_select_3_n,
	input  wire       addr_pin_0,
	input  wire       addr_pin_1,
	input  wire       addr_pin_2,
	output wire       int_n,
	output wire       busy,
	output wire [7:0] spi_config
);

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_ADDR = 3'h1;
	localparam [2:0] S_ACK  = 3'h2;
	localparam [2:0] S_RX   = 3'h3;
	localparam [2:0] S_RXA  = 3'h4;
	localparam [2:0] S_TX   = 3'h5;
	localparam [2:0] S_TXA  = 3'h6;

	localparam [1:0] X_IDLE = 2'h0;
	localparam [1:0] X_NEXT = 2'h1;
	localparam [1:0] X_WAIT = 2'h2;

	localparam [3:0] SEL_MASK = EXT_CLK_VARIANT ? `SS_NO3 : `SS_ALL;

	wire          scl_s;
	wire          sda_s;
	wire          miso_s;
	wire [2:0]    addr_s;

	reg  [2:0]    addr_lo_q;
	reg           scl_p_q;
	reg           sda_p_q;
	reg  [2:0]    st_q;
	reg  [3:0]    cnt_q;
	reg  [7:0]    sh_q;
	reg           rw_q;
	reg           first_q;
	reg           wr_q;
	reg           sda_oe_q;
	reg  [PW-1:0] wlen_q;
	reg  [PW-1:0] rd_q;
	reg  [7:0]    func_q;
	reg  [7:0]    cfg_q;
	reg           go_q;

	reg  [1:0]    x_q;
	reg           busy_q;
	reg  [3:0]    ss_q;
	reg  [PW-1:0] idx_q;
	reg  [PW-1:0] len_q;
	reg           int_q;
	reg           spi_go_q;

	reg  [7:0]    mem [0:DEPTH-1];

	wire          spi_done;
	wire [7:0]    spi_rx;

	in_sync #(
		.W(6)
	) u_sync (
		.ref_clk (ref_clk),
		.d       ({addr_pin_2, addr_pin_1, addr_pin_0, miso, sda_in, scl}),
		.q       ({addr_s, miso_s, sda_s, scl_s})
	);

	wire scl_rise = scl_s & ~scl_p_q;
	wire scl_fall = ~scl_s & scl_p_q;
	wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	wire byte_end = scl_fall && (cnt_q == `BYTE_BITS);

	wire func_spi = (func_q[7:4] == `FC_SPI_NIB) &&
	                (func_q[3:0] != `FC_NONE);
	wire room     = (wlen_q < DEPTH);
	wire addr_ok  = (sh_q[7:1] == {ADDR_HIGH, addr_lo_q}) && !busy_q;

	wire i2c_we   = (st_q == S_RX) && byte_end && !first_q && func_spi && room;
	wire spi_we   = (x_q == X_WAIT) && spi_done;

	wire [PW-1:0] mem_a  = spi_we ? idx_q : wlen_q;
	wire [7:0]    mem_wd = spi_we ? spi_rx : sh_q;
	wire [7:0]    buf_rd = mem[rd_q];
	wire [7:0]    buf_tx = mem[idx_q];
	wire [PW-1:0] rd_nx  = (rd_q == DEPTH - 1'b1) ? {PW{1'b0}} : rd_q + 1'b1;

	// Single write port: I2C fills only when idle, SPI only while busy
	always @(posedge ref_clk) begin
		if (i2c_we | spi_we)
			mem[mem_a] <= mem_wd;
	end

	// Straps caught while reset is held
	always @(posedge ref_clk) begin
		if (!rst_b)
			addr_lo_q <= addr_s;
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			scl_p_q  <= 1'b1;
			sda_p_q  <= 1'b1;
			st_q     <= S_IDLE;
			cnt_q    <= 4'h0;
			sh_q     <= 8'h00;
			rw_q     <= 1'b0;
			first_q  <= 1'b0;
			wr_q     <= 1'b0;
			sda_oe_q <= 1'b0;
			wlen_q   <= {PW{1'b0}};
			rd_q     <= {PW{1'b0}};
			func_q   <= 8'h00;
			cfg_q    <= `CFG_RST;
			go_q     <= 1'b0;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			go_q    <= 1'b0;
			// Only START/STOP seen; never driven, SCL never held
			if (start_ev) begin
				st_q     <= S_ADDR;
				cnt_q    <= 4'h0;
				sda_oe_q <= 1'b0;
				wr_q     <= 1'b0;
			end else if (stop_ev) begin
				st_q     <= S_IDLE;
				sda_oe_q <= 1'b0;
				wr_q     <= 1'b0;
				go_q     <= wr_q && !first_q;
			end else begin
				case (st_q)
				S_ADDR: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end else if (byte_end) begin
						if (addr_ok) begin
							sda_oe_q <= 1'b1;
							rw_q     <= sh_q[0];
							rd_q     <= {PW{1'b0}};
							st_q     <= S_ACK;
						end else begin
							st_q <= S_IDLE;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							sh_q     <= buf_rd;
							sda_oe_q <= ~buf_rd[7];
							st_q     <= S_TX;
						end else begin
							sda_oe_q <= 1'b0;
							first_q  <= 1'b1;
							wr_q     <= 1'b1;
							wlen_q   <= {PW{1'b0}};
							st_q     <= S_RX;
						end
					end
				end
				S_RX: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end else if (byte_end) begin
						cnt_q <= 4'h0;
						st_q  <= S_RXA;
						if (first_q) begin
							func_q   <= sh_q;
							first_q  <= 1'b0;
							sda_oe_q <= 1'b1;
						end else if (func_spi) begin
							// Bytes past the buffer end are refused
							sda_oe_q <= room;
							if (i2c_we)
								wlen_q <= wlen_q + 1'b1;
						end else begin
							sda_oe_q <= 1'b1;
							if (func_q == `FC_CFG && wlen_q == {PW{1'b0}}) begin
								cfg_q  <= sh_q;
								wlen_q <= wlen_q + 1'b1;
							end
						end
					end
				end
				S_RXA: begin
					if (scl_fall) begin
						sda_oe_q <= 1'b0;
						st_q     <= S_RX;
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (cnt_q == `TX_LAST_BIT) begin
							sda_oe_q <= 1'b0;
							st_q     <= S_TXA;
						end else begin
							sh_q     <= {sh_q[6:0], 1'b0};
							sda_oe_q <= ~sh_q[6];
							cnt_q    <= cnt_q + 4'h1;
						end
					end
				end
				S_TXA: begin
					if (scl_rise) begin
						if (sda_s)
							st_q <= S_IDLE;
						else
							rd_q <= rd_nx;
					end else if (scl_fall) begin
						sh_q     <= buf_rd;
						sda_oe_q <= ~buf_rd[7];
						cnt_q    <= 4'h0;
						st_q     <= S_TX;
					end
				end
				default: st_q <= S_IDLE;
				endcase
			end
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			x_q      <= X_IDLE;
			busy_q   <= 1'b0;
			ss_q     <= `SS_IDLE;
			idx_q    <= {PW{1'b0}};
			len_q    <= {PW{1'b0}};
			int_q    <= `INT_IDLE;
			spi_go_q <= 1'b0;
		end else begin
			spi_go_q <= 1'b0;
			case (x_q)
			X_IDLE: begin
				if (go_q) begin
					if (func_q == `FC_CLR_INT)
						int_q <= `INT_IDLE;
					if (func_spi) begin
						busy_q <= 1'b1;
						len_q  <= wlen_q;
						idx_q  <= {PW{1'b0}};
						x_q    <= X_NEXT;
						// Empty message: no select pulse
						if (wlen_q != {PW{1'b0}})
							ss_q <= ~(func_q[3:0] & SEL_MASK);
					end
				end
			end
			X_NEXT: begin
				if (idx_q == len_q) begin
					ss_q   <= `SS_IDLE;
					busy_q <= 1'b0;
					int_q  <= 1'b0;
					x_q    <= X_IDLE;
				end else begin
					spi_go_q <= 1'b1;
					x_q      <= X_WAIT;
				end
			end
			X_WAIT: begin
				if (spi_done) begin
					idx_q <= idx_q + 1'b1;
					x_q   <= X_NEXT;
				end
			end
			default: x_q <= X_IDLE;
			endcase
		end
	end

	spi_shift_master u_spi (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.start     (spi_go_q),
		.tx_byte   (buf_tx),
		.lsb_first (cfg_q[`CFG_ORDER]),
		.cpol      (cfg_q[`CFG_CPOL]),
		.cpha      (cfg_q[`CFG_CPHA]),
		.rate      (cfg_q[`CFG_RATE_HI:`CFG_RATE_LO]),
		.miso_s    (miso_s),
		.sclk      (serial_shift_clock),
		.mosi      (mosi),
		.rx_byte   (spi_rx),
		.done      (spi_done)
	);

	// Open drain: only ever pulls low
	assign sda_out          = 1'b0;
	assign sda_oe           = sda_oe_q;
	assign slave_select_0_n = ss_q[0];
	assign slave_select_1_n = ss_q[1];
	assign slave_select_2_n = ss_q[2];
	assign slave_select_3_n = ss_q[3];
	assign int_n            = int_q;
	assign busy             = busy_q;
	assign spi_config       = cfg_q;

endmodule

// ==== bridge_consts.vh ====
`ifndef BRIDGE_CONSTS_VH
`define BRIDGE_CONSTS_VH
// Operation
// - Acts only as I2C slave receiver or transmitter; never drives START.
// - Byte-oriented I2C slave port works at SCL rates up to 400 kHz.
// - After START compare seven address bits; eighth bit 0 writes, 1 reads.
// - Slave address is fixed upper part plus three address pins.
// - Address pins sampled during reset; later pin changes are ignored.
// - One 200-byte buffer; write message is address, function, 0..200 bytes.
// - Each received data byte is stored in order until STOP.
// - After STOP, addressing is not acknowledged until the function finishes.
// - Function codes 01h..0Fh start SPI; bits 3..0 choose selects 3..0.
// - Every chosen slave select goes low, any combination allowed.
// - SPI sends exactly the received data bytes, same count.
// - MISO byte captured per byte overwrites the same buffer position.
// - Read-direction address returns buffer contents, no function code.
// - Reading the buffer leaves it unchanged.
// - External-clock variant has no fourth select; code bit 3 selects none.
// - Reset input and interrupt output are both active low.
// - Interrupt goes low when SPI completes; function F1h releases it.
// - Config byte: order bit, two-bit mode, two-bit rate; all reset 0.

`define BUF_DEPTH      8'hC8
`define ADDR_HIGH_DEF  4'h5
`define CLK_KHZ        40000
`define I2C_MAX_KHZ    400
`define SCL_MIN_CYC    (`CLK_KHZ / `I2C_MAX_KHZ)
`define FC_SPI_NIB     4'h0
`define FC_NONE        4'h0
`define FC_CFG         8'hF0
`define FC_CLR_INT     8'hF1
`define CFG_RST        8'h00
`define CFG_ORDER      5
`define CFG_CPOL       3
`define CFG_CPHA       2
`define CFG_RATE_HI    1
`define CFG_RATE_LO    0
`define HALF_R0        8'h05
`define HALF_R1        8'h14
`define HALF_R2        8'h50
`define HALF_R3        8'hA0
`define SPI_LAST_HALF  5'h10
`define SPI_LAST_SHIFT 5'h0F
`define BYTE_BITS      4'h8
`define TX_LAST_BIT    4'h7
`define SS_IDLE        4'hF
`define SS_ALL         4'hF
`define SS_NO3         4'h7
`define INT_IDLE       1'b1
`endif

// ==== in_sync.v ====
module in_sync #(
	parameter W = 1
) (
	input  wire         ref_clk,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	reg [W-1:0] f_q;

	// No reset: sync pipe plus agreement filter, settles within four edges of reset
	always @(posedge ref_clk) begin
		s1_q <= d;
		s2_q <= s1_q;
		s3_q <= s2_q;
		f_q  <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
	end

	assign q = f_q;

endmodule

// ==== spi_shift_master.v ====
`include "bridge_consts.vh"
module spi_shift_master (
	input  wire       ref_clk,
	input  wire       rst_b,
	input  wire       start,
	input  wire [7:0] tx_byte,
	input  wire       lsb_first,
	input  wire       cpol,
	input  wire       cpha,
	input  wire [1:0] rate,
	input  wire       miso_s,
	output wire       sclk,
	output wire       mosi,
	output wire [7:0] rx_byte,
	output wire       done
);

	reg       run_q;
	reg [7:0] div_q;
	reg [4:0] h_q;
	reg [7:0] tx_q;
	reg [7:0] rx_q;
	reg [7:0] rxo_q;
	reg       sclk_q;
	reg       mosi_q;
	reg       done_q;
	reg [7:0] half;

	function out_bit;
		input       lsb;
		input [7:0] b;
		begin
			out_bit = lsb ? b[0] : b[7];
		end
	endfunction

	always @* begin
		case (rate)
		2'b00: half = `HALF_R0;
		2'b01: half = `HALF_R1;
		2'b10: half = `HALF_R2;
		default: half = `HALF_R3;
		endcase
	end

	wire       half_end = run_q && (div_q == half - 8'h01);
	// MISO is sampled one half late to absorb the input filter delay
	wire       cap = cpha ? (h_q != 5'h00 && !h_q[0]) : h_q[0];
	wire       upd = (cpha ? !h_q[0] : h_q[0]) && (h_q != 5'h00) &&
	                 (h_q < `SPI_LAST_SHIFT);
	wire [7:0] rx_sh = lsb_first ? {miso_s, rx_q[7:1]} : {rx_q[6:0], miso_s};
	wire [7:0] rx_nx = cap ? rx_sh : rx_q;
	wire [7:0] tx_nx = lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			run_q  <= 1'b0;
			div_q  <= 8'h00;
			h_q    <= 5'h00;
			tx_q   <= 8'h00;
			rx_q   <= 8'h00;
			rxo_q  <= 8'h00;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!run_q) begin
				sclk_q <= cpol;
				if (start) begin
					run_q  <= 1'b1;
					div_q  <= 8'h00;
					h_q    <= 5'h00;
					tx_q   <= tx_byte;
					rx_q   <= 8'h00;
					mosi_q <= out_bit(lsb_first, tx_byte);
				end
			end else if (half_end) begin
				div_q <= 8'h00;
				rx_q  <= rx_nx;
				if (h_q != `SPI_LAST_HALF)
					sclk_q <= ~sclk_q;
				if (upd) begin
					tx_q   <= tx_nx;
					mosi_q <= out_bit(lsb_first, tx_nx);
				end
				if (h_q == `SPI_LAST_HALF) begin
					run_q  <= 1'b0;
					done_q <= 1'b1;
					rxo_q  <= rx_nx;
				end else begin
					h_q <= h_q + 5'h01;
				end
			end else begin
				div_q <= div_q + 8'h01;
			end
		end
	end

	assign sclk    = sclk_q;
	assign mosi    = mosi_q;
	assign rx_byte = rxo_q;
	assign done    = done_q;

endmodule

// ==== spi_slave_model.sv ====
module spi_slave_model (
	input  wire logic        sclk,
	input  wire logic        mosi,
	input  wire logic        sel_n,
	output logic             miso,
	output logic [15:0]      got,
	output logic [7:0]       nbytes
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;
	logic [7:0] tx;
	int         bits;
	initial begin
		miso = 1'b0;
		got = 16'h0000;
		nbytes = 8'h00;
		bits = 0;
		sh = 8'h00;
		tx = 8'hA0;
	end
	// Reply byte k is A0h plus k
	always @(negedge sel_n) begin
		bits = 0;
		miso = tx[7];
	end
	// Released line shows the inverse, not a stale level
	always @(posedge sel_n) miso = ~miso;
	always @(posedge sclk) if (!sel_n) begin
		sh = {sh[6:0], mosi};
		bits++;
		if (bits == 8) begin
			got = {got[7:0], sh};
			nbytes++;
			bits = 0;
			tx = 8'hA0 + nbytes;
		end
	end
	always @(negedge sclk) if (!sel_n) miso = tx[7 - bits];
endmodule

// ==== bridge_chk.sv ====
module bridge_chk #(
	parameter EXT_CLK_VARIANT = 0
) (
	input wire       ref_clk, rst_b, sda_out, sda_oe, mosi,
	input wire       serial_shift_clock, int_n, busy,
	input wire       slave_select_0_n, slave_select_1_n,
	input wire       slave_select_2_n, slave_select_3_n,
	input wire [7:0] spi_config
);
	timeunit 1ns;
	timeprecision 100ps;
	wire [3:0] ss = {slave_select_3_n, slave_select_2_n,
		slave_select_1_n, slave_select_0_n};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_sda_drain: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	a_sel_idle: assert property (!busy |-> ss == 4'hF)
		else $error("select low while idle");
	a_int_on_done: assert property ($fell(busy) |-> !int_n && ss == 4'hF)
		else $error("no interrupt at end");
	a_reset_vals: assert property (disable iff (1'b0) !rst_b |=>
		int_n && !busy && !sda_oe && spi_config == 8'h00)
		else $error("bad reset value");
	a_sel_steady: assert property (busy && ss != 4'hF |=>
		ss == $past(ss) || !busy) else $error("select moved");
	a_clk_idle: assert property (!busy && $stable(spi_config) |->
		serial_shift_clock == spi_config[3]) else $error("clock idle");
	a_busy_nack: assert property (busy |-> !sda_oe)
		else $error("ack while busy");
	a_mosi_hold: assert property (serial_shift_clock &&
		$past(serial_shift_clock) && spi_config[3:2] == 2'b00
		|-> $stable(mosi)) else $error("mosi moved");
	a_no_sel3: assert property (EXT_CLK_VARIANT != 0 |->
		slave_select_3_n) else $error("select 3 used");
endmodule
bind i2c_to_spi_message_bridge bridge_chk #(
	.EXT_CLK_VARIANT(EXT_CLK_VARIANT)
) chk_u (.ref_clk(ref_clk), .rst_b(rst_b), .sda_out(sda_out),
	.sda_oe(sda_oe), .mosi(mosi), .serial_shift_clock(serial_shift_clock),
	.int_n(int_n), .busy(busy), .slave_select_0_n(slave_select_0_n),
	.slave_select_1_n(slave_select_1_n),
	.slave_select_2_n(slave_select_2_n),
	.slave_select_3_n(slave_select_3_n), .spi_config(spi_config));

// ==== i2c_to_spi_message_bridge_tb.sv ====
`include "bridge_consts.vh"
module i2c_to_spi_message_bridge_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam [6:0] ADR = {`ADDR_HIGH_DEF, 3'b101};
	localparam [6:0] ADR2 = {`ADDR_HIGH_DEF, 3'b110};
	logic       ref_clk, rst_b, scl, sda_m, s;
	logic [2:0] pins;
	logic [7:0] r;
	wire        sda_out, sda_oe, miso, mosi, sck, int_n, busy;
	wire        sel0_n, sel1_n, sel2_n, sel3_n;
	wire        sda2_oe, int2_n;
	wire        xsel0_n, xsel1_n, xsel2_n, xsel3_n;
	wire [7:0]  cfg, nbytes;
	wire [15:0] got;
	// Second device shares the bus; its straps differ so it answers only ADR2
	wire [2:0]  pins2 = pins ^ 3'h3;
	wire        sda = sda_m & ~sda_oe & ~sda2_oe;
	wire [7:0]  ssv = {4'h0, sel3_n, sel2_n, sel1_n, sel0_n};
	wire [7:0]  ssv2 = {4'h0, xsel3_n, xsel2_n, xsel1_n, xsel0_n};
	int         mismatches, total_checks;
	i2c_to_spi_message_bridge dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
		.scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.miso(miso), .mosi(mosi), .serial_shift_clock(sck),
		.slave_select_0_n(sel0_n), .slave_select_1_n(sel1_n),
		.slave_select_2_n(sel2_n), .slave_select_3_n(sel3_n),
		.addr_pin_0(pins[0]), .addr_pin_1(pins[1]), .addr_pin_2(pins[2]),
		.int_n(int_n), .busy(busy), .spi_config(cfg));
	spi_slave_model slv_u (.sclk(sck), .mosi(mosi),
		.sel_n(sel0_n & sel1_n & sel2_n & sel3_n), .miso(miso),
		.got(got), .nbytes(nbytes));
	i2c_to_spi_message_bridge #(.EXT_CLK_VARIANT(1)) dut_ext_u (
		.ref_clk(ref_clk), .rst_b(rst_b), .scl(scl), .sda_in(sda),
		.sda_out(), .sda_oe(sda2_oe), .miso(miso), .mosi(),
		.serial_shift_clock(), .slave_select_0_n(xsel0_n),
		.slave_select_1_n(xsel1_n), .slave_select_2_n(xsel2_n),
		.slave_select_3_n(xsel3_n), .addr_pin_0(pins2[0]),
		.addr_pin_1(pins2[1]), .addr_pin_2(pins2[2]),
		.int_n(int2_n), .busy(), .spi_config());
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	task check(input string nm, input logic [7:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Quarter bit of 25 cycles keeps the bus at 400 kHz
	task bit_io(input logic b, output logic v);
		sda_m = b;
		tick(25);
		scl = 1'b1;
		tick(25);
		v = sda;
		tick(25);
		scl = 1'b0;
		tick(25);
	endtask
	task start;
		sda_m = 1'b1;
		tick(25);
		scl = 1'b1;
		tick(25);
		sda_m = 1'b0;
		tick(25);
		scl = 1'b0;
		tick(25);
	endtask
	task stop;
		sda_m = 1'b0;
		tick(25);
		scl = 1'b1;
		tick(25);
		sda_m = 1'b1;
		tick(50);
	endtask
	task wr(input logic [7:0] b, input logic nack);
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		check("ack", {7'h00, s}, {7'h00, nack});
	endtask
	task rd(input logic nack, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(nack, s);
	endtask
	task wait_busy(input logic v);
		int k;
		for (k = 0; k < 20000 && busy !== v; k++) tick(1);
		if (k == 20000) begin
			mismatches++;
			final_report;
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		rst_b = 1'b0;
		scl = 1'b1;
		sda_m = 1'b1;
		pins = 3'b101;
		// Six edges, the input filter has no reset of its own
		tick(6);
		rst_b = 1'b1;
		tick(1);
		check("int_n", {7'h00, int_n}, 8'h01);
		check("cfg", cfg, 8'h00);
		check("ss", ssv, 8'h0F);
		pins = 3'b010;
		start;
		wr({`ADDR_HIGH_DEF, 3'b010, 1'b0}, 1'b1);
		stop;
		$display("test address done");
		start;
		wr({ADR, 1'b0}, 1'b0);
		wr(8'hF0, 1'b0);
		wr(8'h03, 1'b0);
		stop;
		check("cfg", cfg, 8'h03);
		start;
		wr({ADR, 1'b0}, 1'b0);
		wr(8'h02, 1'b0);
		wr(8'h3C, 1'b0);
		wr(8'h96, 1'b0);
		stop;
		wait_busy(1'b1);
		check("ss", ssv, 8'h0D);
		start;
		wr({ADR, 1'b0}, 1'b1);
		stop;
		wait_busy(1'b0);
		check("int_n", {7'h00, int_n}, 8'h00);
		check("mosi0", got[15:8], 8'h3C);
		check("mosi1", got[7:0], 8'h96);
		check("count", nbytes, 8'h02);
		$display("test spi done");
		repeat (2) begin
			start;
			wr({ADR, 1'b1}, 1'b0);
			rd(1'b0, r);
			check("rd0", r, 8'hA0);
			rd(1'b1, r);
			check("rd1", r, 8'hA1);
			stop;
		end
		$display("test read done");
		start;
		wr({ADR, 1'b0}, 1'b0);
		wr(8'hF1, 1'b0);
		stop;
		tick(4);
		check("int_n", {7'h00, int_n}, 8'h01);
		$display("test clear done");
		start;
		wr({ADR2, 1'b0}, 1'b0);
		wr(8'h0F, 1'b0);
		wr(8'h5A, 1'b0);
		stop;
		check("ss_ext", ssv2, 8'h08);
		tick(200);
		check("int_ext", {7'h00, int2_n}, 8'h00);
		check("ss_ext_idle", ssv2, 8'h0F);
		$display("test variant done");
		start;
		wr({ADR, 1'b0}, 1'b0);
		wr(8'hF0, 1'b0);
		wr(8'h2C, 1'b0);
		stop;
		check("cfg", cfg, 8'h2C);
		start;
		wr({ADR, 1'b0}, 1'b0);
		wr(8'h01, 1'b0);
		wr(8'h0F, 1'b0);
		stop;
		wait_busy(1'b1);
		check("ss", ssv, 8'h0E);
		wait_busy(1'b0);
		check("mosi_lsb", got[7:0], 8'hF0);
		check("count", nbytes, 8'h03);
		start;
		wr({ADR, 1'b1}, 1'b0);
		rd(1'b1, r);
		check("rd_lsb", r, 8'h45);
		stop;
		$display("test mode done");
		final_report;
	end
endmodule
